// ---- stop_reset_pkg.sv ----
// Constants for the stop-release and reset sequencer
package stop_reset_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned STALL_PERIODS = 17;
  localparam logic [4:0] STALL_COUNT = 5'h11;
  localparam logic [15:0] RESET_VECTOR_LO = 16'h0000;
  localparam logic [15:0] RESET_VECTOR_HI = 16'h0001;
  // ==========================================================
  // Cause flag bit positions
  localparam int unsigned CAUSE_WDT_BIT = 0;
  localparam int unsigned CAUSE_CLM_BIT = 1;
  localparam int unsigned CAUSE_LVI_BIT = 2;
  localparam logic [2:0] CAUSE_RESET_VALUE = 3'h0;
  // ==========================================================
  // Sequencer states
  typedef enum logic [4:0] {
    ST_RESET = 5'b0_0001,
    ST_STALL = 5'b0_0010,
    ST_RUN = 5'b0_0100,
    ST_STOP = 5'b0_1000,
    ST_OSC_WAIT = 5'b1_0000
  } seq_state_e;
endpackage : stop_reset_pkg

// ---- stop_reset_ctrl.sv ----
// Stop mode release, reset merging, restart stall and reset cause flags
//
// Behaviour
// - Unmasked request ends stop; after osc wait take vector if enabled, else next.
// - Mask 1 holds stop; mask 0 wakes; service needs enable, low priority needs isp.
// - External reset ends stop; reset processing after osc wait regardless of flags.
// - Pin, watchdog, clock monitor, power-on-clear, low voltage merge into one reset.
// - After reset execution starts from vector at 0000H/0001H.
// - During reset and following wait, ports float except one pin driven low.
// - After pin release, processor clock stalls 17 ring periods then runs on ring.
// - Watchdog and clock monitor resets self release, then same 17 period stall.
// - Power-on-clear and low voltage release when supply good, then 17 period stall.
// - During reset, main crystal and ring oscillator clocks are halted.
// - Reset out of stop keeps retained state; ports still float.
// - Cause register holds watchdog, clock monitor and low voltage flags, readable.
// - In stop, async port runs only when clocked from running timer a.
// - In stop, clocked serial port needs external clock; converter and monitor stop.
// - In stop, second interval timer runs only on ring clock over 128.
// - In stop, watch timer runs only when subsystem clock selected.
// - Low voltage reset leaves the detector and its configuration untouched.
// - Watchdog reset also reinitializes the watchdog timer.
`timescale 1ns/1ps
module stop_reset_ctrl
  import stop_reset_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ext_reset_b_in,
  input wire logic watchdog_overflow_in,
  input wire logic clock_monitor_stop_in,
  input wire logic power_on_clear_in,
  input wire logic low_voltage_detect_in,
  input wire logic ring_osc_tick_in,
  input wire logic stop_request_in,
  input wire logic osc_wait_done_in,
  input wire logic int_request_in,
  input wire logic interrupt_mask_flag_in,
  input wire logic interrupt_priority_flag_in,
  input wire logic global_interrupt_enable_in,
  input wire logic in_service_priority_flag_in,
  input wire logic cause_read_in,
  input wire logic uart_clk_from_timer_a_in,
  input wire logic eight_bit_timer_a_running_in,
  input wire logic csi_ext_clk_sel_in,
  input wire logic interval_timer_ring_div_sel_in,
  input wire logic watch_timer_subclk_sel_in,
  output logic internal_reset_out,
  output logic cpu_clk_enable_out,
  output logic main_osc_enable_out,
  output logic ring_osc_enable_out,
  output logic take_vector_out,
  output logic next_instr_out,
  output logic [15:0] fetch_vector_addr_out,
  output logic port_float_out,
  output logic forced_low_port_pin_out,
  output logic forced_low_port_pin_oe_out,
  output logic retain_state_out,
  output logic stop_mode_out,
  output logic [2:0] reset_cause_register_out,
  output logic watchdog_reinit_out,
  output logic lvd_config_reset_out,
  output logic async_serial_port_a_run_out,
  output logic clocked_serial_port_run_out,
  output logic converter_run_out,
  output logic clock_monitor_run_out,
  output logic interval_timer_run_out,
  output logic watch_timer_run_out
);

  // ==========================================================
  // Reset merging
  logic any_reset;
  logic pin_or_poc;
  assign any_reset = !ext_reset_b_in || watchdog_overflow_in || clock_monitor_stop_in ||
                     power_on_clear_in || low_voltage_detect_in;
  assign pin_or_poc = !ext_reset_b_in || power_on_clear_in;

  // ==========================================================
  // Sequencer
  seq_state_e state_reg, state_next;
  logic [4:0] stall_reg, stall_next;
  logic from_stop_reg, from_stop_next;
  logic reset_pend_reg, reset_pend_next;
  logic wake_svc_reg, wake_svc_next;
  logic take_vec_next, next_instr_next;
  logic wake_ok, svc_ok;

  assign wake_ok = int_request_in && !interrupt_mask_flag_in;
  assign svc_ok = global_interrupt_enable_in &&
                  (!interrupt_priority_flag_in || in_service_priority_flag_in);

  always_comb begin
    state_next = state_reg;
    stall_next = stall_reg;
    from_stop_next = from_stop_reg;
    reset_pend_next = reset_pend_reg;
    wake_svc_next = wake_svc_reg;
    take_vec_next = 1'b0;
    next_instr_next = 1'b0;
    case (state_reg)
      ST_RESET: begin
        stall_next = 5'h00;
        if (!any_reset) begin
          state_next = ST_STALL;
        end
      end
      ST_STALL: begin
        // Stall counted in ring oscillator periods, not system clocks
        if (any_reset) begin
          state_next = ST_RESET;
        end else if (ring_osc_tick_in) begin
          if (stall_reg == STALL_COUNT - 5'h01) begin
            state_next = ST_RUN;
            from_stop_next = 1'b0;
            take_vec_next = 1'b1;
          end else begin
            stall_next = stall_reg + 5'h01;
          end
        end
      end
      ST_RUN: begin
        if (any_reset) begin
          state_next = ST_RESET;
        end else if (stop_request_in) begin
          state_next = wake_ok ? ST_OSC_WAIT : ST_STOP;
          wake_svc_next = svc_ok;
          reset_pend_next = 1'b0;
        end
      end
      ST_STOP: begin
        if (!ext_reset_b_in) begin
          state_next = ST_OSC_WAIT;
          reset_pend_next = 1'b1;
          from_stop_next = 1'b1;
        end else if (any_reset) begin
          state_next = ST_RESET;
          from_stop_next = 1'b1;
        end else if (wake_ok) begin
          state_next = ST_OSC_WAIT;
          wake_svc_next = svc_ok;
        end
      end
      ST_OSC_WAIT: begin
        if (!ext_reset_b_in) begin
          reset_pend_next = 1'b1;
        end
        if (osc_wait_done_in) begin
          if (reset_pend_reg || !ext_reset_b_in) begin
            state_next = ST_RESET;
          end else begin
            state_next = ST_RUN;
            take_vec_next = wake_svc_reg;
            next_instr_next = !wake_svc_reg;
          end
        end
      end
      default: begin
        state_next = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= ST_RESET;
      stall_reg <= 5'h00;
      from_stop_reg <= 1'b0;
      reset_pend_reg <= 1'b0;
      wake_svc_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      stall_reg <= stall_next;
      from_stop_reg <= from_stop_next;
      reset_pend_reg <= reset_pend_next;
      wake_svc_reg <= wake_svc_next;
    end
  end

  // ==========================================================
  // Cause flags
  logic [2:0] cause_reg, cause_next;
  always_comb begin
    cause_next = cause_reg;
    if (cause_read_in || pin_or_poc) begin
      cause_next = CAUSE_RESET_VALUE;
    end
    // Set wins over a read clear in the same cycle
    if (watchdog_overflow_in) begin
      cause_next[CAUSE_WDT_BIT] = 1'b1;
    end
    if (clock_monitor_stop_in) begin
      cause_next[CAUSE_CLM_BIT] = 1'b1;
    end
    if (low_voltage_detect_in) begin
      cause_next[CAUSE_LVI_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cause_reg <= CAUSE_RESET_VALUE;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // ==========================================================
  // Registered outputs
  logic in_reset_next;
  logic stop_next;
  logic internal_reset_next;
  logic cpu_clk_enable_next;
  logic main_osc_enable_next;
  logic ring_osc_enable_next;
  logic [15:0] fetch_vector_addr_next;
  logic port_float_next;
  logic pin_oe_next;
  logic retain_state_next;
  logic watchdog_reinit_next;
  logic lvd_config_reset_next;
  logic async_port_run_next;
  logic clocked_port_run_next;
  logic converter_run_next;
  logic clock_monitor_run_next;
  logic interval_timer_run_next;
  logic watch_timer_run_next;

  always_comb begin
    // Reset taken in stop floats ports through the wait
    in_reset_next = (state_next == ST_RESET) || (state_next == ST_STALL) ||
                    ((state_next == ST_OSC_WAIT) && reset_pend_next);
    stop_next = (state_next == ST_STOP);
    internal_reset_next = (state_next == ST_RESET);
    cpu_clk_enable_next = (state_next == ST_RUN);
    // Oscillators rest in every reset cycle, restart with the stall
    main_osc_enable_next = !any_reset && !internal_reset_next && !stop_next;
    ring_osc_enable_next = !any_reset && !internal_reset_next;
    fetch_vector_addr_next = (state_next == ST_STALL) ? RESET_VECTOR_HI :
                             RESET_VECTOR_LO;
    port_float_next = in_reset_next;
    pin_oe_next = in_reset_next;
    retain_state_next = from_stop_next && (state_next != ST_RUN);
    watchdog_reinit_next = any_reset &&
                           (watchdog_overflow_in || !low_voltage_detect_in);
    lvd_config_reset_next = any_reset && !low_voltage_detect_in;
    async_port_run_next = !stop_next ||
                          (uart_clk_from_timer_a_in && eight_bit_timer_a_running_in);
    clocked_port_run_next = !stop_next || csi_ext_clk_sel_in;
    converter_run_next = !stop_next;
    clock_monitor_run_next = !stop_next && !in_reset_next;
    interval_timer_run_next = !stop_next || interval_timer_ring_div_sel_in;
    watch_timer_run_next = !stop_next || watch_timer_subclk_sel_in;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      internal_reset_out <= 1'b1;
      cpu_clk_enable_out <= 1'b0;
      main_osc_enable_out <= 1'b0;
      ring_osc_enable_out <= 1'b0;
      take_vector_out <= 1'b0;
      next_instr_out <= 1'b0;
      fetch_vector_addr_out <= RESET_VECTOR_LO;
      port_float_out <= 1'b1;
      forced_low_port_pin_out <= 1'b0;
      forced_low_port_pin_oe_out <= 1'b1;
      retain_state_out <= 1'b0;
      stop_mode_out <= 1'b0;
      reset_cause_register_out <= CAUSE_RESET_VALUE;
      watchdog_reinit_out <= 1'b0;
      lvd_config_reset_out <= 1'b0;
      async_serial_port_a_run_out <= 1'b0;
      clocked_serial_port_run_out <= 1'b0;
      converter_run_out <= 1'b0;
      clock_monitor_run_out <= 1'b0;
      interval_timer_run_out <= 1'b0;
      watch_timer_run_out <= 1'b0;
    end else begin
      internal_reset_out <= internal_reset_next;
      cpu_clk_enable_out <= cpu_clk_enable_next;
      main_osc_enable_out <= main_osc_enable_next;
      ring_osc_enable_out <= ring_osc_enable_next;
      take_vector_out <= take_vec_next;
      next_instr_out <= next_instr_next;
      fetch_vector_addr_out <= fetch_vector_addr_next;
      port_float_out <= port_float_next;
      forced_low_port_pin_out <= 1'b0;
      forced_low_port_pin_oe_out <= pin_oe_next;
      retain_state_out <= retain_state_next;
      stop_mode_out <= stop_next;
      reset_cause_register_out <= cause_next;
      watchdog_reinit_out <= watchdog_reinit_next;
      lvd_config_reset_out <= lvd_config_reset_next;
      async_serial_port_a_run_out <= async_port_run_next;
      clocked_serial_port_run_out <= clocked_port_run_next;
      converter_run_out <= converter_run_next;
      clock_monitor_run_out <= clock_monitor_run_next;
      interval_timer_run_out <= interval_timer_run_next;
      watch_timer_run_out <= watch_timer_run_next;
    end
  end

endmodule : stop_reset_ctrl

// ---- stop_reset_partner.sv ----
// Far-side model: ring oscillator ticks and oscillation wait timer
`timescale 1ns/1ps
module stop_reset_partner (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ring_osc_enable_out,
  input wire logic stop_mode_out,
  input wire logic cpu_clk_enable_out,
  output logic ring_osc_tick_in,
  output logic osc_wait_done_in
);
  logic [1:0] div_reg;
  logic [3:0] wait_reg;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_reg <= 2'h0;
      wait_reg <= 4'h0;
    end else begin
      div_reg <= ring_osc_enable_out ? div_reg + 2'h1 : 2'h0;
      if (stop_mode_out || cpu_clk_enable_out) begin
        wait_reg <= 4'h0;
      end else if (wait_reg != 4'hf) begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
  // Ticks stay quiet while the ring is halted
  assign ring_osc_tick_in = (div_reg == 2'h3);
  assign osc_wait_done_in = (wait_reg == 4'h5);
endmodule : stop_reset_partner

// ---- stop_reset_sva.sv ----
// Checker for the stop-release and reset sequencer
`timescale 1ns/1ps
module stop_reset_sva (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ext_reset_b_in,
  input wire logic watchdog_overflow_in,
  input wire logic clock_monitor_stop_in,
  input wire logic power_on_clear_in,
  input wire logic low_voltage_detect_in,
  input wire logic int_request_in,
  input wire logic interrupt_mask_flag_in,
  input wire logic internal_reset_out,
  input wire logic cpu_clk_enable_out,
  input wire logic main_osc_enable_out,
  input wire logic ring_osc_enable_out,
  input wire logic take_vector_out,
  input wire logic next_instr_out,
  input wire logic port_float_out,
  input wire logic forced_low_port_pin_out,
  input wire logic forced_low_port_pin_oe_out,
  input wire logic stop_mode_out,
  input wire logic [2:0] reset_cause_register_out,
  input wire logic converter_run_out,
  input wire logic clock_monitor_run_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_held;
    stop_mode_out && int_request_in && interrupt_mask_flag_in && ext_reset_b_in &&
    !watchdog_overflow_in && !clock_monitor_stop_in && !power_on_clear_in &&
    !low_voltage_detect_in;
  endsequence
  float_in_reset_a: assert property (internal_reset_out |->
      port_float_out && forced_low_port_pin_oe_out)
    else $error("ports not floating in reset");
  pin_low_a: assert property (!forced_low_port_pin_out)
    else $error("forced pin not low");
  osc_halt_a: assert property (internal_reset_out |->
      !ring_osc_enable_out && !main_osc_enable_out)
    else $error("oscillator running in reset");
  merge_src_a: assert property (watchdog_overflow_in |=> internal_reset_out)
    else $error("source gave no reset");
  start_kind_a: assert property ($rose(cpu_clk_enable_out) |->
      take_vector_out || next_instr_out)
    else $error("restart without start pulse");
  pulse_one_a: assert property (take_vector_out |=> !take_vector_out && !next_instr_out)
    else $error("start pulse too long");
  mask_hold_a: assert property (s_held |=> stop_mode_out)
    else $error("masked request woke core");
  stop_periph_a: assert property (stop_mode_out |->
      !converter_run_out && !clock_monitor_run_out)
    else $error("converter or monitor runs in stop");
  wdt_flag_a: assert property (watchdog_overflow_in |=> reset_cause_register_out[0])
    else $error("watchdog flag not set");
endmodule : stop_reset_sva
bind stop_reset_ctrl stop_reset_sva sva_u (.*);

// ---- tb_stop_reset_ctrl.sv ----
// Testbench for the stop-release and reset sequencer
`timescale 1ns/1ps
module tb_stop_reset_ctrl;
  logic clk_in, rst_b_in, ext_reset_b_in, watchdog_overflow_in, clock_monitor_stop_in;
  logic power_on_clear_in, low_voltage_detect_in, ring_osc_tick_in, stop_request_in;
  logic osc_wait_done_in, int_request_in, interrupt_mask_flag_in, interrupt_priority_flag_in;
  logic global_interrupt_enable_in, in_service_priority_flag_in, cause_read_in;
  logic uart_clk_from_timer_a_in, eight_bit_timer_a_running_in, csi_ext_clk_sel_in;
  logic interval_timer_ring_div_sel_in, watch_timer_subclk_sel_in, take_vector_out;
  logic internal_reset_out, cpu_clk_enable_out, main_osc_enable_out, ring_osc_enable_out;
  logic next_instr_out, port_float_out, forced_low_port_pin_out, forced_low_port_pin_oe_out;
  logic retain_state_out, stop_mode_out, watchdog_reinit_out, lvd_config_reset_out;
  logic async_serial_port_a_run_out, clocked_serial_port_run_out, converter_run_out;
  logic clock_monitor_run_out, interval_timer_run_out, watch_timer_run_out;
  logic [15:0] fetch_vector_addr_out;
  logic [2:0] reset_cause_register_out;
  int n_errors = 0;
  int samples_checked = 0;
  int ticks;
  stop_reset_ctrl dut_u (.*);
  stop_reset_partner partner_u (.*);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // Counts stall ticks until the core clock returns
  task automatic wait_run;
    ticks = 0;
    for (int i = 0; i < 400 && cpu_clk_enable_out !== 1'b1; i++) begin
      if (internal_reset_out) ticks = 0;
      else if (ring_osc_tick_in) ticks++;
      @(negedge clk_in);
    end
  endtask : wait_run
  task automatic t_src(input int k, input logic [2:0] cause);
    logic [4:0] s;
    s = 5'h01 << k;
    {low_voltage_detect_in, power_on_clear_in} = s[4:3];
    {clock_monitor_stop_in, watchdog_overflow_in} = s[2:1];
    ext_reset_b_in = !s[0];
    repeat (4) @(negedge clk_in);
    chk({internal_reset_out, port_float_out, forced_low_port_pin_oe_out,
      ring_osc_enable_out, main_osc_enable_out}, 5'h1c);
    if (k == 1) chk(watchdog_reinit_out, 1);
    chk(lvd_config_reset_out, k != 4);
    {low_voltage_detect_in, power_on_clear_in, clock_monitor_stop_in, watchdog_overflow_in} = 4'h0;
    ext_reset_b_in = 1;
    @(negedge clk_in);
    chk(fetch_vector_addr_out, 16'h0001);
    wait_run;
    chk(ticks[15:0], 16'h0011);
    chk(take_vector_out, 1);
    chk(reset_cause_register_out, cause);
  endtask : t_src
  // Flags are {mask, low priority, enable, in-service}
  task automatic t_stop(input logic [3:0] f, input logic [1:0] exp);
    {interrupt_mask_flag_in, interrupt_priority_flag_in} = f[3:2];
    {global_interrupt_enable_in, in_service_priority_flag_in} = f[1:0];
    stop_request_in = 1;
    @(negedge clk_in);
    stop_request_in = 0;
    chk({stop_mode_out, converter_run_out, clock_monitor_run_out, watch_timer_run_out,
      interval_timer_run_out, clocked_serial_port_run_out, async_serial_port_a_run_out},
      7'h4f);
    int_request_in = 1;
    repeat (6) @(negedge clk_in);
    chk(stop_mode_out, f[3]);
    interrupt_mask_flag_in = 0;
    wait_run;
    chk({take_vector_out, next_instr_out}, exp);
    int_request_in = 0;
  endtask : t_stop
  task automatic t_stop_rst;
    {uart_clk_from_timer_a_in, eight_bit_timer_a_running_in, csi_ext_clk_sel_in} = 3'h2;
    {interval_timer_ring_div_sel_in, watch_timer_subclk_sel_in} = 2'h0;
    stop_request_in = 1;
    @(negedge clk_in);
    stop_request_in = 0;
    chk({stop_mode_out, watch_timer_run_out, interval_timer_run_out,
      clocked_serial_port_run_out, async_serial_port_a_run_out}, 5'h10);
    ext_reset_b_in = 0;
    repeat (2) @(negedge clk_in);
    chk({stop_mode_out, retain_state_out, port_float_out}, 3'h3);
    repeat (20) @(negedge clk_in);
    chk(internal_reset_out, 1);
    ext_reset_b_in = 1;
    wait_run;
    chk({ticks[4:0], take_vector_out}, 6'h23);
  endtask : t_stop_rst
  initial begin
    clk_in = 0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    #200000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    {rst_b_in, watchdog_overflow_in, clock_monitor_stop_in, power_on_clear_in} = 4'h0;
    {low_voltage_detect_in, stop_request_in, int_request_in, cause_read_in} = 4'h0;
    {interrupt_mask_flag_in, interrupt_priority_flag_in} = 2'h0;
    {global_interrupt_enable_in, in_service_priority_flag_in} = 2'h0;
    {uart_clk_from_timer_a_in, eight_bit_timer_a_running_in, csi_ext_clk_sel_in} = 3'h7;
    {interval_timer_ring_div_sel_in, watch_timer_subclk_sel_in, ext_reset_b_in} = 3'h7;
    repeat (8) @(negedge clk_in);
    rst_b_in = 1;
    wait_run;
    chk({ticks[4:0], take_vector_out}, 6'h23);
    t_src(1, 3'h1);
    t_src(2, 3'h3);
    t_src(4, 3'h7);
    t_src(0, 3'h0);
    t_src(2, 3'h2);
    t_src(3, 3'h0);
    t_src(1, 3'h1);
    cause_read_in = 1;
    @(negedge clk_in);
    cause_read_in = 0;
    @(negedge clk_in);
    chk(reset_cause_register_out, 0);
    t_stop(4'h0, 2'h1);
    t_stop(4'h2, 2'h2);
    t_stop(4'h5, 2'h1);
    t_stop(4'h4, 2'h1);
    t_stop(4'h7, 2'h2);
    t_stop(4'h6, 2'h1);
    t_stop(4'ha, 2'h2);
    t_stop_rst;
    report_and_stop;
  end
endmodule : tb_stop_reset_ctrl
